/* File: design/ocs_pkg.sv */
// shared constants and types for the one-time-programmable configuration store
`default_nettype none
package ocs_pkg;
  localparam int CLK_PERIOD_NS   = 40;
  // least durations of the fuse operations, rounded up to whole cycles
  localparam int REFRESH_TIME_NS = 2000;
  localparam int PROGRAM_TIME_NS = 100000;
  localparam int REFRESH_CYC     = (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC     = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 12;

  localparam int FUSE_BITS = 40;
  localparam int CFG_BITS  = 39;
  localparam int SLICE_W   = 10;
  localparam int LOCK_BIT  = 39;
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 5;

  localparam logic [ADDR_W-1:0] ADDR_CFG0     = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_CFG1     = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_CFG2     = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_CFG3     = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_READOUT  = 5'h1E;
  localparam logic [ADDR_W-1:0] ADDR_REVISION = 5'h1F;

  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_SLICE_LSB = 2;
  localparam int CTRL_BIAS_L    = 4;
  localparam int CTRL_BIAS_H    = 5;
  localparam int STAT_ACTIVE    = 0;
  localparam int STAT_FAIL      = 1;
  localparam int STAT_REFUSED   = 2;

  localparam logic [1:0] OP_REFRESH    = 2'h1;
  localparam logic [1:0] OP_PROGRAM    = 2'h2;
  localparam logic [1:0] REV_TOP_FIXED = 2'h0;

  // configuration field positions inside the fuse word
  localparam int F_CH1_VTH  = 0;
  localparam int F_CH1_SNS  = 8;
  localparam int F_CH2_VTH  = 10;
  localparam int F_CH2_SNS  = 18;
  localparam int F_CH1_OFF  = 20;
  localparam int F_CH2_OFF  = 25;
  localparam int F_CH1_EN   = 30;
  localparam int F_CH2_EN   = 31;
  localparam int F_FS_MODE  = 32;
  localparam int F_CH1_TAR  = 35;
  localparam int F_CH2_TAR  = 36;
  localparam int F_OC_THR   = 37;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_BOOT    = 4'h2,
    ST_REFRESH = 4'h4,
    ST_PROGRAM = 4'h8
  } ocs_state_t;

  function automatic logic [SLICE_W-1:0] ocs_slice_of(input logic [FUSE_BITS-1:0] bits, input logic [1:0] sel);
    ocs_slice_of = bits[sel * SLICE_W +: SLICE_W];
  endfunction : ocs_slice_of
endpackage : ocs_pkg
`default_nettype wire

/* File: design/ocs_fuse_array.sv */
// fuse array with timed refresh and program cycles
`default_nettype none
module ocs_fuse_array
  import ocs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start_refresh,
  input  wire logic                 start_program,
  input  wire logic [FUSE_BITS-1:0] prog_data,
  output logic                      busy,
  output logic                      done,
  output logic [FUSE_BITS-1:0]      fuse_q
);
  typedef struct packed {
    logic [FUSE_BITS-1:0] bits;
    logic [FUSE_BITS-1:0] pend;
    logic [CNT_W-1:0]     cnt;
    logic                 busy;
    logic                 prog;
    logic                 done;
  } ocs_fuse_t;

  ocs_fuse_t f_reg;
  ocs_fuse_t f_next;

  always_comb begin
    f_next      = f_reg;
    f_next.done = 1'b0;
    if (!f_reg.busy && (start_refresh || start_program)) begin
      f_next.busy = 1'b1;
      f_next.prog = start_program;
      f_next.pend = prog_data;
      f_next.cnt  = start_program ? CNT_W'(PROGRAM_CYC - 1) : CNT_W'(REFRESH_CYC - 1);
    end else if (f_reg.busy) begin
      if (f_reg.cnt == '0) begin
        f_next.busy = 1'b0;
        f_next.done = 1'b1;
        // blown fuses never return to zero
        if (f_reg.prog) begin
          f_next.bits = f_reg.bits | f_reg.pend;
        end
      end else begin
        f_next.cnt = f_reg.cnt - 1'b1;
      end
    end
  end

  // reset stands in for an unblown array; silicon fuses keep their state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  assign busy   = f_reg.busy;
  assign done   = f_reg.done;
  assign fuse_q = f_reg.bits;
endmodule : ocs_fuse_array
`default_nettype wire

/* File: design/ocs_config_store.sv */
// register access to the one-time-programmable configuration store and revision
//
// How it works
// - thirty-nine of the forty fuse bits hold the configuration
// - fixed fuse ranges feed fields; bit 39 locks
// - power-up refresh loads the default configuration
// - readout shows selected ten-bit slice after a code 1 refresh, not after the power-up refresh
// - code 1 refreshes all bits; 0, 3 idle
// - code 2 programs configuration plus lock bit
// - program refused once lock bit is set
// - active bit high during any operation
// - low programming supply during program latches fail
// - latched flags clear on read
// - revision encodes fixed, derivative, mask, package, metal
// - revision at 0x1F, fixed at reset
// - readout at 0x1E, zero after reset
`default_nettype none
module ocs_config_store
  import ocs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              program_supply_undervoltage,
  input  wire logic              strap_derivative,
  input  wire logic [1:0]        strap_mask_version,
  input  wire logic              strap_package,
  input  wire logic [1:0]        strap_metal_tune,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   otp_active,
  output logic      [7:0]        ch1_voltage_threshold,
  output logic      [1:0]        ch1_sense_threshold,
  output logic      [7:0]        ch2_voltage_threshold,
  output logic      [1:0]        ch2_sense_threshold,
  output logic      [4:0]        ch1_off_time,
  output logic      [4:0]        ch2_off_time,
  output logic                   ch1_enable,
  output logic                   ch2_enable,
  output logic      [2:0]        failsafe_mode_code,
  output logic                   ch1_thermal_autorecover,
  output logic                   ch2_thermal_autorecover,
  output logic      [1:0]        overcurrent_compare_threshold
);
  typedef struct packed {
    ocs_state_t           st;
    logic [CFG_BITS-1:0]  cfg;
    logic [1:0]           slice;
    logic                 bias_l;
    logic                 bias_h;
    logic [SLICE_W-1:0]   readout;
    logic [7:0]           revision;
    logic                 fail;
    logic                 refused;
    logic [DATA_W-1:0]    rdata;
    logic [2:0]           uv_sync;
    logic                 uv_level;
    logic                 start_ref;
    logic                 start_prog;
    logic                 active;
  } ocs_main_t;

  ocs_main_t            s_reg;
  ocs_main_t            s_next;
  logic                 fuse_busy;
  logic                 fuse_done;
  logic [FUSE_BITS-1:0] fuse_q;
  logic                 op_write;
  logic [1:0]           op_code;
  logic                 fail_set;
  logic                 status_read;
  logic                 refresh_end;
  logic [SLICE_W-1:0]   refresh_slice;

  ocs_fuse_array u_fuse (
    .clk           (clk),
    .rst_n         (rst_n),
    .start_refresh (s_reg.start_ref),
    .start_program (s_reg.start_prog),
    .prog_data     ({1'b1, s_reg.cfg}),
    .busy          (fuse_busy),
    .done          (fuse_done),
    .fuse_q        (fuse_q)
  );

  assign op_write      = reg_wr && (reg_addr == ADDR_CTRL);
  assign op_code       = reg_wdata[CTRL_OP_LSB +: 2];
  assign status_read   = reg_rd && (reg_addr == ADDR_STATUS);
  assign fail_set      = (s_reg.st == ST_PROGRAM) && s_reg.uv_level;
  assign refresh_end   = (s_reg.st == ST_REFRESH) && fuse_done;
  assign refresh_slice = ocs_slice_of(fuse_q, s_reg.slice);

  always_comb begin
    s_next            = s_reg;
    s_next.start_ref  = 1'b0;
    s_next.start_prog = 1'b0;
    // third stage is compared with the second before the level moves
    s_next.uv_sync    = {s_reg.uv_sync[1:0], program_supply_undervoltage};
    if (s_reg.uv_sync[2] == s_reg.uv_sync[1]) begin
      s_next.uv_level = s_reg.uv_sync[2];
    end

    // clear on read, a same-cycle event still wins
    if (status_read) begin
      s_next.fail    = 1'b0;
      s_next.refused = 1'b0;
    end
    if (fail_set) begin
      s_next.fail = 1'b1;
    end

    if (reg_wr) begin
      case (reg_addr)
        ADDR_CFG0: s_next.cfg[0 +: SLICE_W]           = reg_wdata[SLICE_W-1:0];
        ADDR_CFG1: s_next.cfg[SLICE_W +: SLICE_W]     = reg_wdata[SLICE_W-1:0];
        ADDR_CFG2: s_next.cfg[2 * SLICE_W +: SLICE_W] = reg_wdata[SLICE_W-1:0];
        ADDR_CFG3: s_next.cfg[CFG_BITS-1:3 * SLICE_W] = reg_wdata[SLICE_W-2:0];
        ADDR_CTRL: begin
          s_next.slice  = reg_wdata[CTRL_SLICE_LSB +: 2];
          s_next.bias_l = reg_wdata[CTRL_BIAS_L];
          s_next.bias_h = reg_wdata[CTRL_BIAS_H];
        end
        default: begin
        end
      endcase
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (op_write) begin
          // refresh on code 1, codes 0 and 3 do nothing
          if (op_code == OP_REFRESH) begin
            s_next.start_ref = 1'b1;
            s_next.st        = ST_REFRESH;
          end else if (op_code == OP_PROGRAM) begin
            // program only while lock fuse is blank
            if (fuse_q[LOCK_BIT]) begin
              s_next.refused = 1'b1;
            end else begin
              // configuration and lock bit blown together
              s_next.start_prog = 1'b1;
              s_next.st         = ST_PROGRAM;
            end
          end
        end
      end
      ST_BOOT: begin
        if (fuse_done) begin
          s_next.cfg = fuse_q[CFG_BITS-1:0];
          s_next.st  = ST_IDLE;
        end
      end
      ST_REFRESH: begin
        if (fuse_done) begin
          s_next.readout = refresh_slice;
          s_next.st      = ST_IDLE;
        end
      end
      ST_PROGRAM: begin
        if (fuse_done) begin
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    s_next.active = (s_next.st != ST_IDLE);

    s_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG0:     s_next.rdata = DATA_W'(ocs_slice_of({1'b0, s_reg.cfg}, 2'h0));
        ADDR_CFG1:     s_next.rdata = DATA_W'(ocs_slice_of({1'b0, s_reg.cfg}, 2'h1));
        ADDR_CFG2:     s_next.rdata = DATA_W'(ocs_slice_of({1'b0, s_reg.cfg}, 2'h2));
        ADDR_CFG3:     s_next.rdata = DATA_W'(ocs_slice_of({1'b0, s_reg.cfg}, 2'h3));
        ADDR_CTRL:     s_next.rdata = DATA_W'({s_reg.bias_h, s_reg.bias_l, s_reg.slice, 2'h0});
        ADDR_STATUS:   s_next.rdata = DATA_W'({s_reg.refused, s_reg.fail, s_reg.active});
        ADDR_READOUT:  s_next.rdata = DATA_W'(s_reg.readout);
        ADDR_REVISION: s_next.rdata = DATA_W'(s_reg.revision);
        default:       s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg           <= '0;
      s_reg.st        <= ST_BOOT;
      s_reg.start_ref <= 1'b1;
      s_reg.active    <= 1'b1;
      s_reg.revision  <= {REV_TOP_FIXED, strap_derivative, strap_mask_version, strap_package, strap_metal_tune};
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata  = s_reg.rdata;
  assign otp_active = s_reg.active;
  // fixed fuse ranges drive the configuration fields
  assign ch1_voltage_threshold         = s_reg.cfg[F_CH1_VTH +: 8];
  assign ch1_sense_threshold           = s_reg.cfg[F_CH1_SNS +: 2];
  assign ch2_voltage_threshold         = s_reg.cfg[F_CH2_VTH +: 8];
  assign ch2_sense_threshold           = s_reg.cfg[F_CH2_SNS +: 2];
  assign ch1_off_time                  = s_reg.cfg[F_CH1_OFF +: 5];
  assign ch2_off_time                  = s_reg.cfg[F_CH2_OFF +: 5];
  assign ch1_enable                    = s_reg.cfg[F_CH1_EN];
  assign ch2_enable                    = s_reg.cfg[F_CH2_EN];
  assign failsafe_mode_code            = s_reg.cfg[F_FS_MODE +: 3];
  assign ch1_thermal_autorecover       = s_reg.cfg[F_CH1_TAR];
  assign ch2_thermal_autorecover       = s_reg.cfg[F_CH2_TAR];
  assign overcurrent_compare_threshold = s_reg.cfg[F_OC_THR +: 2];

  a_refresh_start: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.st == ST_IDLE) && op_write && (op_code == OP_REFRESH) |=> (s_reg.st == ST_REFRESH) ##1 fuse_busy)
    else $error("refresh code did not start a refresh");
  a_lock_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.st == ST_IDLE) && op_write && (op_code == OP_PROGRAM) && fuse_q[LOCK_BIT]
      |=> s_reg.refused && !s_reg.start_prog && (s_reg.st == ST_IDLE))
    else $error("program accepted with lock set");
  a_active_busy: assert property (@(posedge clk) disable iff (!rst_n)
    fuse_busy |-> otp_active)
    else $error("active low while fuse busy");
  a_done_idle: assert property (@(posedge clk) disable iff (!rst_n)
    fuse_done |=> !otp_active && (s_reg.st == ST_IDLE))
    else $error("active did not drop at end");
  a_readout_slice: assert property (@(posedge clk) disable iff (!rst_n)
    refresh_end |=> (s_reg.readout == $past(refresh_slice)))
    else $error("readout not the selected slice");
  a_readout_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !refresh_end |=> $stable(s_reg.readout))
    else $error("readout changed outside refresh end");
  a_fail_latch: assert property (@(posedge clk) disable iff (!rst_n)
    fail_set |=> s_reg.fail [*1] ##1 (s_reg.fail || $past(status_read)))
    else $error("fail flag not latched");
  a_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    status_read && !fail_set |=> !s_reg.fail && (reg_rdata[STAT_FAIL] == $past(s_reg.fail)))
    else $error("fail flag not cleared by read");
  a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.st != ST_IDLE) && op_write |=> !s_reg.start_ref && !s_reg.start_prog)
    else $error("code accepted while busy");
  a_rev_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> $stable(s_reg.revision) && (s_reg.revision[7:6] == REV_TOP_FIXED))
    else $error("revision changed after reset");
endmodule : ocs_config_store
`default_nettype wire

/* File: tb/ocs_host_model.sv */
// register-port host model for the configuration store
`default_nettype none
module ocs_host_model
  import ocs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output var  logic              reg_wr,
  output var  logic              reg_rd,
  output var  logic [ADDR_W-1:0] reg_addr,
  output var  logic [DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
  end

  // one access: drive on a falling edge, taken at the next rising edge
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                      output logic [DATA_W-1:0] rdata);
    @(negedge clk);
    reg_wr    = ~rd;
    reg_rd    = rd;
    reg_addr  = a;
    reg_wdata = v;
    @(posedge clk);
    @(negedge clk);
    rdata     = reg_rdata;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // idle bus shows the inverse, so a stale value never looks valid
    reg_addr  = ~a;
    reg_wdata = ~v;
  endtask : xfer
endmodule : ocs_host_model
`default_nettype wire

/* File: tb/ocs_config_store_test.sv */
// self-checking bench for the configuration store register access
`default_nettype none
module ocs_config_store_test
  import ocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                uv = 1'b0;
  logic                sd, sp, wr, rd, act, e1, e2, t1, t2;
  logic [1:0]          sm, st, s1, s2, oc;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wd, rdat;
  logic [7:0]          v1, v2;
  logic [4:0]          o1, o2;
  logic [2:0]          fs;
  logic [CFG_BITS-1:0] cfg, cfg_out;
  int                  errors = 0;
  int                  n_tests = 0;

  assign cfg_out = {oc, t2, t1, fs, e2, e1, o2, o1, s2, v2, s1, v1};
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ocs_host_model u_host (.clk(clk), .reg_rdata(rdat), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd));
  ocs_config_store u_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .program_supply_undervoltage(uv), .strap_derivative(sd), .strap_mask_version(sm),
    .strap_package(sp), .strap_metal_tune(st), .reg_rdata(rdat), .otp_active(act),
    .ch1_voltage_threshold(v1), .ch1_sense_threshold(s1), .ch2_voltage_threshold(v2),
    .ch2_sense_threshold(s2), .ch1_off_time(o1), .ch2_off_time(o2), .ch1_enable(e1),
    .ch2_enable(e2), .failsafe_mode_code(fs), .ch1_thermal_autorecover(t1),
    .ch2_thermal_autorecover(t2), .overcurrent_compare_threshold(oc)
  );

  function automatic logic [DATA_W-1:0] exp_rev();
    exp_rev = {8'h00, 2'h0, sd, sm, sp, st};
  endfunction : exp_rev

  function automatic logic [DATA_W-1:0] exp_slice(input logic [FUSE_BITS-1:0] f, input int s);
    exp_slice = {6'h00, f[s*SLICE_W +: SLICE_W]};
  endfunction : exp_slice

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [CFG_BITS-1:0] got, input logic [CFG_BITS-1:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    logic [DATA_W-1:0] d;
    u_host.xfer(1'b1, a, '0, d);
    chk(CFG_BITS'(d), CFG_BITS'(exp), what);
  endtask : rchk

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] d;
    u_host.xfer(1'b0, a, v, d);
  endtask : wreg

  // bounded wait for the active flag to drop; returns cycles waited
  task automatic wait_idle(input int bound, output int n);
    n = 0;
    while (act !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        errors++;
        $display("[ERR] %0t wait for idle ran out", $time);
        tally_and_finish();
      end
    end
  endtask : wait_idle

  initial begin
    int                   n;
    logic [FUSE_BITS-1:0] fuse;
    logic [DATA_W-1:0]    prev;
    void'($urandom(65486));
    {sd, sm, sp, st} = 6'($urandom);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rchk(ADDR_READOUT, 16'h0000, "readout after reset");
    rchk(ADDR_REVISION, exp_rev(), "revision");
    wreg(ADDR_REVISION, ~exp_rev());
    rchk(ADDR_REVISION, exp_rev(), "revision after write");
    // stale register content must give way to the boot load
    wreg(ADDR_CFG0, 16'h03FF);
    chk(CFG_BITS'(act), 39'h1, "active during boot");
    wait_idle(200, n);
    chk(cfg_out, 39'h0, "boot config from blank store");
    $display("test reset done");

    cfg = CFG_BITS'({$urandom, $urandom});
    for (int i = 0; i < 4; i++)
      wreg(ADDR_W'(ADDR_CFG0 + i), DATA_W'(cfg >> (i * SLICE_W)) & 16'h03FF);
    for (int i = 0; i < 4; i++)
      rchk(ADDR_W'(ADDR_CFG0 + i), DATA_W'(cfg >> (i * SLICE_W)) & 16'h03FF, "config readback");
    chk(cfg_out, cfg, "config fields");
    for (int op = 0; op < 4; op += 3) begin
      wreg(ADDR_CTRL, DATA_W'(op));
      chk(CFG_BITS'(act), 39'h0, "no-op code");
    end
    $display("test config done");

    wreg(ADDR_CTRL, DATA_W'(OP_PROGRAM));
    repeat (2) @(negedge clk);
    uv = 1'b1;
    repeat (10) @(negedge clk);
    uv = 1'b0;
    // let the synchronised level fall first, else a read and a set collide
    repeat (5) @(negedge clk);
    wreg(ADDR_CTRL, DATA_W'(OP_REFRESH));
    rchk(ADDR_STATUS, 16'h0003, "status in failing program");
    rchk(ADDR_STATUS, 16'h0001, "fail flag after read");
    wait_idle(PROGRAM_CYC + 100, n);
    chk(CFG_BITS'(n > PROGRAM_CYC - 100), 39'h1, "program duration");
    repeat (3) @(negedge clk);
    chk(CFG_BITS'(act), 39'h0, "code ignored while busy");
    rchk(ADDR_STATUS, 16'h0000, "status after program");
    $display("test program done");

    fuse = {1'b1, cfg};
    prev = 16'h0000;
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 4; s++) begin
        wreg(ADDR_CTRL, DATA_W'((b << 5) | ((1 - b) << 4) | (s << 2)));
        rchk(ADDR_CTRL, DATA_W'((b << 5) | ((1 - b) << 4) | (s << 2)), "control readback");
        rchk(ADDR_READOUT, prev, "readout before refresh");
        wreg(ADDR_CTRL, DATA_W'((b << 5) | ((1 - b) << 4) | (s << 2) | 1));
        chk(CFG_BITS'(act), 39'h1, "refresh active");
        wait_idle(100, n);
        prev = exp_slice(fuse, s);
        rchk(ADDR_READOUT, prev, "slice readout");
      end
    end
    $display("test verify done");

    wreg(ADDR_CTRL, DATA_W'(OP_PROGRAM));
    chk(CFG_BITS'(act), 39'h0, "program after lock");
    rchk(ADDR_STATUS, 16'h0004, "refused flag");
    rchk(ADDR_STATUS, 16'h0000, "refused flag after read");
    $display("test lock done");

    {sd, sm, sp, st} = 6'($urandom);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rchk(ADDR_REVISION, exp_rev(), "revision after second reset");
    rchk(ADDR_READOUT, 16'h0000, "readout after second reset");
    wait_idle(200, n);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : ocs_config_store_test
`default_nettype wire
